// File: can_bit_timing_tx_flags.sv
// Bit timing, transmit buffer empty flags and an AXI4-Lite register slave.
// How it works
// - Prescale divide is six-bit code plus one.
// - Timing registers writable only in init mode.
// - Sample bit clear: one sample at point.
// - Sample bit set: majority of three samples.
// - Segment two bits 6:4, segment one 3:0.
// - Flags held reset in init; writable outside.
// - Writing one clears an empty flag.
// - Flag one means empty, zero means scheduled.
// - Successful transmission sets the empty flag.
// - Successful abort also sets the empty flag.
// - Interrupt while any unmasked flag is set.
// - Clearing a flag clears its abort acknowledge.
// - Setting a flag clears its abort request.
// - Listen-only blocks flag clears and transmission.
// - Scheduled buffers refuse reads and writes.
// - Three independent buffers, each with a flag.
module can_bit_timing_tx_flags #(
	parameter int NUM_BUFS = 3,
	parameter int BUF_BITS = 32
) (
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite write address and data
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	// AXI4-Lite write response
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	// AXI4-Lite read
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	// CAN pins
	input  wire logic        can_rx,
	output logic             can_tx,
	// Received bit stream and interrupt
	output logic             rx_bit,
	output logic             rx_bit_valid,
	output logic             tx_irq
);

	// ********************************
	// Parameter checks
	// ********************************
	if (NUM_BUFS < 1 || NUM_BUFS > 3) begin : g_bad_bufs
		$error("NUM_BUFS must lie between 1 and 3");
	end
	if (BUF_BITS < 2 || BUF_BITS > 32) begin : g_bad_bits
		$error("BUF_BITS must lie between 2 and 32");
	end
	localparam int NB = NUM_BUFS;
	function automatic logic maj3(input logic a, input logic b,
		input logic c);
		maj3 = (a & b) | (a & c) | (b & c);
	endfunction
	// Index of the buffer word at an address, or NB if none.
	function automatic int buf_index(input logic [7:0] addr);
		buf_index = NB;
		for (int i = 0; i < NB; i++) begin
			if (addr == can_bt_pkg::OFF_BUF0 + 8'(4 * i)) begin
				buf_index = i;
			end
		end
	endfunction
	function automatic logic [NB-1:0] lowest_one(input logic [NB-1:0] v);
		lowest_one = v & (~v + NB'(1));
	endfunction

	// ********************************
	// State
	// ********************************
	logic [5:0]              baud_prescale_sel;
	can_bt_pkg::bit_timing_s bus_bit_timing_cfg;
	logic [NB-1:0]           tx_buf_empty;
	logic [NB-1:0]           abort_request;
	logic [NB-1:0]           abort_ack;
	logic [NB-1:0]           tx_irq_enable_reg;
	logic                    init_request;
	logic                    init_ack;
	logic                    listen_only;
	logic [BUF_BITS-1:0]     buf_data [NB];
	logic [5:0]              presc_cnt;
	logic [4:0]              quantum;
	logic                    rx_meta;
	logic                    rx_sync;
	logic [1:0]              rx_hist;
	logic                    tx_active;
	logic [NB-1:0]           tx_sel;
	logic [BUF_BITS-1:0]     tx_shift;
	logic [5:0]              tx_cnt;

	// ********************************
	// Bus decode
	// ********************************
	wire        wr_do     = awready & awvalid & wvalid;
	wire        rd_do     = arready & arvalid;
	wire        in_init   = init_request & init_ack;
	wire        flags_wen = ~init_request & ~init_ack;
	wire        wr_lane0  = wr_do & wstrb[0];
	wire        wr_presc  = wr_lane0 & awaddr == can_bt_pkg::OFF_PRESCALE;
	wire        wr_btr    = wr_lane0 & awaddr == can_bt_pkg::OFF_BTR;
	wire        wr_tflg   = wr_lane0 & awaddr == can_bt_pkg::OFF_TFLG;
	wire        wr_ctrl   = wr_lane0 & awaddr == can_bt_pkg::OFF_CTRL;
	wire        wr_irq_en = wr_lane0 & awaddr == can_bt_pkg::OFF_IRQ_EN;
	wire        wr_abort  = wr_lane0 & awaddr == can_bt_pkg::OFF_ABORT_RQ;
	wire integer wr_buf    = buf_index(awaddr);
	wire integer rd_buf    = buf_index(araddr);
	// A scheduled buffer is locked against both directions.
	wire        wr_buf_ok = wr_buf < NB && tx_buf_empty[wr_buf % NB];
	wire        rd_buf_ok = rd_buf < NB && tx_buf_empty[rd_buf % NB];
	wire        wr_known  = awaddr <= can_bt_pkg::OFF_ABORT_AK &&
		awaddr[1:0] == 2'h0;
	wire        rd_known  = araddr <= can_bt_pkg::OFF_ABORT_AK &&
		araddr[1:0] == 2'h0;
	logic [31:0] rd_word;
	always_comb begin
		rd_word = 32'h0000_0000;
		if (araddr == can_bt_pkg::OFF_PRESCALE) begin
			rd_word[5:0] = baud_prescale_sel;
		end else if (araddr == can_bt_pkg::OFF_BTR) begin
			rd_word[7:0] = bus_bit_timing_cfg;
		end else if (araddr == can_bt_pkg::OFF_TFLG) begin
			rd_word[NB-1:0] = tx_buf_empty;
		end else if (araddr == can_bt_pkg::OFF_CTRL) begin
			rd_word[can_bt_pkg::CTRL_INIT_RQ_BIT] = init_request;
			rd_word[can_bt_pkg::CTRL_LISTEN_BIT]  = listen_only;
			rd_word[can_bt_pkg::CTRL_INIT_AK_BIT] = init_ack;
			rd_word[can_bt_pkg::CTRL_BUSY_BIT]    = tx_active;
		end else if (araddr == can_bt_pkg::OFF_IRQ_EN) begin
			rd_word[NB-1:0] = tx_irq_enable_reg;
		end else if (araddr == can_bt_pkg::OFF_ABORT_RQ) begin
			rd_word[NB-1:0] = abort_request;
		end else if (araddr == can_bt_pkg::OFF_ABORT_AK) begin
			rd_word[NB-1:0] = abort_ack;
		end else if (rd_buf_ok) begin
			rd_word[BUF_BITS-1:0] = buf_data[rd_buf % NB];
		end
	end

	// ********************************
	// Bit timing
	// ********************************
	wire [4:0] seg1_q   = {1'b0, bus_bit_timing_cfg.first_segment_len};
	wire [4:0] seg2_q   = {2'b0, bus_bit_timing_cfg.second_segment_len};
	// Quantum 0 is sync, segment one follows, segment two ends the bit.
	wire [4:0] bit_last = seg1_q + seg2_q + can_bt_pkg::SEG_FIXED_QUANTA;
	wire [4:0] triple_sample_sel_q   = seg1_q + 5'h01;
	wire       tq_tick  = presc_cnt == baud_prescale_sel;
	wire       bit_end  = tq_tick & quantum == bit_last;
	wire       triple_sample_sel_pt  = tq_tick & quantum == triple_sample_sel_q;

	// ********************************
	// Transmit scheduling and flags
	// ********************************
	wire [NB-1:0] pend     = ~tx_buf_empty & ~abort_request;
	// Listen-only never starts a frame.
	wire          tx_start = bit_end & ~tx_active & ~listen_only &
		~in_init & |pend;
	wire [NB-1:0] start_oh = lowest_one(pend);
	wire          tx_last  = tx_cnt == 6'(BUF_BITS - 1);
	// A buffer already on the wire finishes instead of being withdrawn.
	wire [NB-1:0] done_ev  = (tx_active & bit_end & tx_last) ?
		tx_sel : '0;
	wire [NB-1:0] abort_ev = ~tx_buf_empty & abort_request &
		~(tx_active ? tx_sel : '0);
	wire [NB-1:0] set_ev   = done_ev | abort_ev;
	wire [NB-1:0] clr_ev   = (wr_tflg & flags_wen & ~listen_only) ?
		wdata[NB-1:0] : '0;
	// Hardware set wins over a software clear in the same cycle.
	wire [NB-1:0] next_flags = in_init ? '1 :
		(tx_buf_empty | set_ev) & ~(clr_ev & ~set_ev);
	wire [NB-1:0] next_abort_request = in_init ? '0 :
		(abort_request | (wr_abort ? wdata[NB-1:0] & ~tx_buf_empty : '0))
		& ~set_ev;
	wire [NB-1:0] next_abort_ack = in_init ? '0 :
		(abort_ack & ~clr_ev) | abort_ev;

	// ********************************
	// Registers
	// ********************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b0;
			wready  <= 1'b0;
			bvalid  <= 1'b0;
			bresp   <= can_bt_pkg::RESP_OKAY;
		end else begin
			awready <= awvalid & wvalid & ~bvalid & ~awready;
			wready  <= awvalid & wvalid & ~bvalid & ~awready;
			if (wr_do) begin
				bvalid <= 1'b1;
				bresp  <= (wr_known || wr_buf_ok) ?
					can_bt_pkg::RESP_OKAY : can_bt_pkg::RESP_SLVERR;
			end else if (bready) begin
				bvalid <= 1'b0;
			end
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b0;
			rvalid  <= 1'b0;
			rdata   <= 32'h0000_0000;
			rresp   <= can_bt_pkg::RESP_OKAY;
		end else begin
			arready <= arvalid & ~rvalid & ~arready;
			if (rd_do) begin
				rvalid <= 1'b1;
				rdata  <= rd_word;
				rresp  <= (rd_known || rd_buf_ok) ?
					can_bt_pkg::RESP_OKAY : can_bt_pkg::RESP_SLVERR;
			end else if (rready) begin
				rvalid <= 1'b0;
			end
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			baud_prescale_sel  <= can_bt_pkg::PRESCALE_RESET;
			bus_bit_timing_cfg <= can_bt_pkg::BTR_RESET;
			init_request       <= 1'b0;
			init_ack           <= 1'b0;
			listen_only        <= 1'b0;
			tx_irq_enable_reg  <= '0;
		end else begin
			if (wr_presc && in_init) begin
				baud_prescale_sel <= wdata[5:0];
			end
			if (wr_btr && in_init) begin
				bus_bit_timing_cfg <= wdata[7:0];
			end
			if (wr_ctrl) begin
				init_request <= wdata[can_bt_pkg::CTRL_INIT_RQ_BIT];
				listen_only  <= wdata[can_bt_pkg::CTRL_LISTEN_BIT];
			end
			init_ack <= init_request;
			if (wr_irq_en) begin
				tx_irq_enable_reg <= wdata[NB-1:0];
			end
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_buf_empty  <= '1;
			abort_request <= '0;
			abort_ack     <= '0;
			tx_irq        <= 1'b0;
		end else begin
			tx_buf_empty  <= next_flags;
			abort_request <= next_abort_request;
			abort_ack     <= next_abort_ack;
			tx_irq <= |(next_flags & tx_irq_enable_reg);
		end
	end
	// Buffer words keep their contents across reset; software loads them.
	always_ff @(posedge aclk) begin
		for (int i = 0; i < NB; i++) begin
			for (int b = 0; b < 4; b++) begin
				if (wr_do && wr_buf == i && tx_buf_empty[i] && wstrb[b] &&
					8 * b < BUF_BITS) begin
					buf_data[i][8*b +: 8] <= wdata[8*b +: 8];
				end
			end
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn || in_init) begin
			presc_cnt <= 6'h00;
			quantum   <= 5'h00;
		end else begin
			presc_cnt <= tq_tick ? 6'h00 : presc_cnt + 6'h01;
			quantum   <= bit_end ? 5'h00 : quantum + 5'(tq_tick);
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_meta      <= 1'b1;
			rx_sync      <= 1'b1;
			rx_hist      <= 2'h3;
			rx_bit       <= 1'b1;
			rx_bit_valid <= 1'b0;
		end else begin
			rx_meta      <= can_rx;
			rx_sync      <= rx_meta;
			rx_bit_valid <= triple_sample_sel_pt & ~in_init;
			rx_hist      <= tq_tick ? {rx_hist[0], rx_sync} : rx_hist;
			if (triple_sample_sel_pt) begin
				rx_bit <= bus_bit_timing_cfg.triple_sample_sel ?
					maj3(rx_hist[1], rx_hist[0], rx_sync) :
					rx_sync;
			end
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn || in_init) begin
			tx_active <= 1'b0;
			tx_sel    <= '0;
			tx_shift  <= '0;
			tx_cnt    <= 6'h00;
			can_tx    <= 1'b1;
		end else if (tx_start) begin
			tx_active <= 1'b1;
			tx_sel    <= start_oh;
			for (int i = 0; i < NB; i++) begin
				if (start_oh[i]) begin
					tx_shift <= buf_data[i] >> 1;
					can_tx   <= buf_data[i][0];
				end
			end
			tx_cnt <= 6'h00;
		end else if (tx_active && bit_end) begin
			if (tx_last) begin
				tx_active <= 1'b0;
				can_tx    <= 1'b1;
			end else begin
				can_tx   <= tx_shift[0];
				tx_shift <= tx_shift >> 1;
				tx_cnt   <= tx_cnt + 6'h01;
			end
		end
	end
endmodule // can_bit_timing_tx_flags

// File: can_bt_monitor.sv
// Port checker for the CAN timing and transmit flag block.
module can_bt_monitor (
	// Clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// Register bus
	input wire logic        awready,
	input wire logic        bvalid,
	input wire logic        arvalid,
	input wire logic        arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0]  rresp,
	input wire logic        rvalid,
	input wire logic        rready,
	// CAN side
	input wire logic        can_rx,
	input wire logic        can_tx,
	input wire logic        rx_bit,
	input wire logic        rx_bit_valid
);
	timeunit 1ns;
	timeprecision 1ns;
	// ********************************
	// Bus quiet time
	// ********************************
	// Saturates so a long idle line never wraps back to looking busy.
	logic [7:0] quiet;
	always_ff @(posedge aclk) begin
		if (!aresetn || $changed(can_rx)) begin
			quiet <= 8'h00;
		end else if (quiet != 8'hFF) begin
			quiet <= quiet + 8'h01;
		end
	end

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	a_rx_pulse_gap: assert property (rx_bit_valid |=> !rx_bit_valid [*2])
		else $error("bit valid pulses too close");
	a_rx_only_sample: assert property ($changed(rx_bit) |-> rx_bit_valid)
		else $error("received bit moved off the sample point");
	a_rx_steady_value: assert property (rx_bit_valid && quiet > 8'hC8 |-> rx_bit == can_rx)
		else $error("received bit differs from a steady line");
	a_tx_bit_hold: assert property ($changed(can_tx) |=> $stable(can_tx) [*2])
		else $error("transmit bit shorter than three cycles");
	a_write_answer: assert property (awready |=> bvalid)
		else $error("write response late");
	a_read_answer: assert property (arready && arvalid |=> rvalid)
		else $error("read response late");
	a_read_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data dropped before taken");
	a_err_zero: assert property (rvalid && rresp == can_bt_pkg::RESP_SLVERR |-> rdata == '0)
		else $error("refused read returned data");
endmodule // can_bt_monitor

bind can_bit_timing_tx_flags can_bt_monitor mon (
	.aclk, .aresetn, .awready, .bvalid, .arvalid, .arready, .rdata, .rresp,
	.rvalid, .rready, .can_rx, .can_tx, .rx_bit, .rx_bit_valid
);

// File: can_bt_pkg.sv
// Package of offsets, layouts and reset values for the CAN timing block.
package can_bt_pkg;

	// ********************************
	// Register byte offsets
	// ********************************
	localparam logic [7:0] OFF_PRESCALE = 8'h00;
	localparam logic [7:0] OFF_BTR      = 8'h04;
	localparam logic [7:0] OFF_TFLG     = 8'h08;
	localparam logic [7:0] OFF_CTRL     = 8'h0C;
	localparam logic [7:0] OFF_IRQ_EN   = 8'h10;
	localparam logic [7:0] OFF_ABORT_RQ = 8'h14;
	localparam logic [7:0] OFF_ABORT_AK = 8'h18;
	localparam logic [7:0] OFF_BUF0     = 8'h20;

	// ********************************
	// Field positions and reset values
	// ********************************
	localparam int         CTRL_INIT_RQ_BIT = 0;
	localparam int         CTRL_LISTEN_BIT  = 1;
	localparam int         CTRL_INIT_AK_BIT = 8;
	localparam int         CTRL_BUSY_BIT    = 9;
	localparam logic [5:0] PRESCALE_RESET   = 6'h00;
	localparam logic [7:0] BTR_RESET        = 8'h00;
	localparam logic [4:0] SEG_FIXED_QUANTA = 5'h02;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Bit timing register layout, bit 7 down to bit 0.
	typedef struct packed {
		logic       triple_sample_sel;
		logic [2:0] second_segment_len;
		logic [3:0] first_segment_len;
	} bit_timing_s;

endpackage

// File: can_bus_node.sv
// Model of the other nodes on the CAN bus.
module can_bus_node (
	// Bus levels
	input  wire logic can_tx,
	input  wire logic dominant,
	output logic      can_rx
);
	timeunit 1ns;
	timeprecision 1ns;
	// Wired-AND line: any dominant node wins over recessive high.
	assign can_rx = can_tx & ~dominant;
endmodule // can_bus_node

// File: tb_top.sv
// Self-checking testbench for the CAN timing and transmit flag block.
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [1:0] OK = can_bt_pkg::RESP_OKAY;
	localparam logic [1:0] ER = can_bt_pkg::RESP_SLVERR;
	logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid, dom;
	logic        can_rx, can_tx, rx_bit, rx_bit_valid, tx_irq;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, w, cap;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	logic [33:0] qr[$];
	logic [1:0]  qb[$];
	int          fails, checks_done, n, p, s1, s2, tr;

	can_bit_timing_tx_flags DUT (.aclk, .aresetn, .awaddr, .awvalid, .awready,
		.wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
		.arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .can_rx, .can_tx,
		.rx_bit, .rx_bit_valid, .tx_irq);
	can_bus_node node (.can_tx, .dominant(dom), .can_rx);

	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end

	task chk(input logic [33:0] s, input logic [33:0] e);
		checks_done++;
		if (s !== e) begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, s, e);
		end
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		qb.push_back(r);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		@(posedge aclk iff (awready && wready));
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		@(posedge aclk iff bvalid);
		bready <= 1'b0;
		@(posedge aclk);
	endtask

	task rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		qr.push_back({r, d});
		araddr <= a;
		arvalid <= 1'b1;
		@(posedge aclk iff arready);
		arvalid <= 1'b0;
		@(posedge aclk);
		rready <= 1'b1;
		@(posedge aclk iff rvalid);
		rready <= 1'b0;
		@(posedge aclk);
	endtask

	task final_report;
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// Results are compared in the order their notes were queued.
	always @(posedge aclk) begin
		if (rvalid && rready) chk({rresp, rdata}, qr.pop_front());
		if (bvalid && bready) chk(34'(bresp), 34'(qb.pop_front()));
	end

	initial begin
		repeat (30000) @(posedge aclk);
		fails++;
		final_report;
	end

	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, dom} = '0;
		{awaddr, araddr, wdata} = '0;
		wstrb = 4'hF;
		fails = 0;
		checks_done = 0;
		void'($urandom(32'hD462));
		p = 1 + $urandom % 3;
		s1 = 3 + $urandom % 13;
		s2 = $urandom % 8;
		tr = $urandom % 2;
		w = $urandom & 32'hFFFF_FFFE;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(can_bt_pkg::OFF_TFLG, 32'h07, OK);
		wr(can_bt_pkg::OFF_BTR, 32'h5A, OK);
		rd(can_bt_pkg::OFF_BTR, 32'h00, OK);
		wr(can_bt_pkg::OFF_CTRL, 32'h01, OK);
		rd(can_bt_pkg::OFF_CTRL, 32'h101, OK);
		wr(can_bt_pkg::OFF_PRESCALE, 32'(p), OK);
		rd(can_bt_pkg::OFF_PRESCALE, 32'(p), OK);
		wr(can_bt_pkg::OFF_BTR, 32'(tr * 128 + s2 * 16 + s1), OK);
		rd(can_bt_pkg::OFF_BTR, 32'(tr * 128 + s2 * 16 + s1), OK);
		wr(can_bt_pkg::OFF_TFLG, 32'h01, OK);
		rd(can_bt_pkg::OFF_TFLG, 32'h07, OK);
		wr(can_bt_pkg::OFF_CTRL, 32'h00, OK);
		@(posedge aclk iff rx_bit_valid);
		n = 0;
		do begin
			@(posedge aclk);
			n++;
		end while (!rx_bit_valid);
		chk(34'(n), 34'((p + 1) * (s1 + s2 + 3)));
		wr(can_bt_pkg::OFF_BUF0, w, OK);
		wr(can_bt_pkg::OFF_IRQ_EN, 32'h01, OK);
		#1 chk(34'(tx_irq), 34'h1);
		@(posedge aclk);
		wr(can_bt_pkg::OFF_TFLG, 32'h01, OK);
		#1 chk(34'(tx_irq), 34'h0);
		@(posedge aclk iff !can_tx);
		fork
			for (int i = 0; i < 32; i++) begin
				@(posedge aclk iff rx_bit_valid) #1;
				cap[i] = can_tx;
				chk(34'(rx_bit), 34'(can_tx));
			end
			begin
				rd(can_bt_pkg::OFF_BUF0, 32'h00, ER);
				wr(can_bt_pkg::OFF_TFLG, 32'h02, OK);
				wr(can_bt_pkg::OFF_ABORT_RQ, 32'h02, OK);
				rd(can_bt_pkg::OFF_ABORT_AK, 32'h02, OK);
				rd(can_bt_pkg::OFF_ABORT_RQ, 32'h00, OK);
				wr(can_bt_pkg::OFF_TFLG, 32'h02, OK);
				rd(can_bt_pkg::OFF_ABORT_AK, 32'h00, OK);
				wr(can_bt_pkg::OFF_ABORT_RQ, 32'h02, OK);
				rd(can_bt_pkg::OFF_TFLG, 32'h06, OK);
			end
		join
		@(posedge aclk iff tx_irq);
		chk(34'(cap), 34'(w));
		rd(can_bt_pkg::OFF_TFLG, 32'h07, OK);
		// Flip the sampling mode so the line check runs in the other mode.
		wr(can_bt_pkg::OFF_CTRL, 32'h03, OK);
		wr(can_bt_pkg::OFF_BTR, 32'((1 - tr) * 128 + s2 * 16 + s1), OK);
		wr(can_bt_pkg::OFF_CTRL, 32'h02, OK);
		wr(can_bt_pkg::OFF_TFLG, 32'h04, OK);
		rd(can_bt_pkg::OFF_TFLG, 32'h07, OK);
		dom <= 1'b1;
		repeat (2) @(posedge aclk iff rx_bit_valid);
		#1 chk(34'(rx_bit), 34'h0);
		@(posedge aclk);
		rd(8'h1C, 32'h00, ER);
		wr(8'h1C, 32'h01, ER);
		repeat (4) @(posedge aclk);
		final_report;
	end
endmodule // tb_top
